// ==== hdl/dctq_qualifier.sv ====
// codeword trigger qualifier in front of one waveform sequencer core
`timescale 1ns/1ps
`default_nettype none

module dctq_qualifier #(
  parameter int NCH = dctq_pkg::NCH_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire dctq_pkg::dctq_cfg_t cfg_i,
  input wire logic [31:0] port_i,
  input wire logic [31:0] link_data_i,
  input wire logic link_valid_i,
  input wire logic external_sample_clock_in_i,
  input wire logic [3:0] trig_in_i,
  input wire logic trig_clear_i,
  input wire logic err_clear_i,
  input wire logic start_req_i,
  input wire logic [NCH-1:0] sync_en_all_i,
  input wire logic [NCH-1:0] sync_ready_all_i,
  output logic seq_trig_o,
  output logic cw_valid_o,
  output logic [9:0] cw_o,
  output logic seq_start_o,
  output dctq_pkg::dctq_stat_t stat_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic detect(input dctq_pkg::dctq_slope_t sl, input logic cur, input logic prev);
    case (sl)
      dctq_pkg::DCTQ_SLOPE_LEVEL: detect = cur;
      dctq_pkg::DCTQ_SLOPE_RISE: detect = cur & ~prev;
      dctq_pkg::DCTQ_SLOPE_FALL: detect = ~cur & prev;
      default: detect = cur ^ prev;
    endcase
  endfunction

  // indexes below the qualifier range fall back to its lowest bit
  function automatic logic [4:0] clamp_idx(input logic [4:0] idx);
    clamp_idx = (idx < dctq_pkg::VALID_IDX_MIN) ? dctq_pkg::VALID_IDX_MIN : idx;
  endfunction

  // set wins over clear, so an event that lands on the clear cycle is kept
  function automatic logic sticky(input logic hit, input logic clr, input logic cur);
    sticky = hit | (~clr & cur);
  endfunction

  // shift first, then mask, so the mask always addresses the low codeword bits
  function automatic logic [9:0] form_cw(input logic [31:0] word, input logic [4:0] sh, input logic [9:0] msk);
    logic [31:0] moved;
    moved = word >> sh;
    form_cw = moved[9:0] & msk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input sampling with decimation

  // the external clock is taken as synchronous: one stage plus a delayed copy finds its edges
  logic ext_clk_ff, ext_clk_q_ff;
  logic [31:0] decim_cnt_ff, nxt_decim_cnt;
  logic [31:0] samp_ff, nxt_samp, prev_samp_ff, nxt_prev_samp;
  logic samp_new_ff, nxt_samp_new;
  logic tick;

  always_comb begin
    tick = 1'b0;
    nxt_decim_cnt = decim_cnt_ff;
    // external clock counted on its rising edge, internal clock every cycle
    if (!cfg_i.ext_clk_sel || (ext_clk_ff && !ext_clk_q_ff)) begin
      // a decimation of 0 or 1 latches on every counted edge
      if (decim_cnt_ff + 32'h00000001 >= cfg_i.decim) begin
        nxt_decim_cnt = 32'h00000000;
        tick = 1'b1;
      end else begin
        nxt_decim_cnt = decim_cnt_ff + 32'h00000001;
      end
    end
    nxt_samp = tick ? port_i : samp_ff;
    nxt_prev_samp = tick ? samp_ff : prev_samp_ff;
    nxt_samp_new = tick;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_clk_ff <= 1'b0;
      ext_clk_q_ff <= 1'b0;
      decim_cnt_ff <= 32'h00000000;
      samp_ff <= dctq_pkg::PORT_RST;
      prev_samp_ff <= dctq_pkg::PORT_RST;
      samp_new_ff <= 1'b0;
    end else begin
      ext_clk_ff <= external_sample_clock_in_i;
      ext_clk_q_ff <= ext_clk_ff;
      decim_cnt_ff <= nxt_decim_cnt;
      samp_ff <= nxt_samp;
      prev_samp_ff <= nxt_prev_samp;
      samp_new_ff <= nxt_samp_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // codeword qualification

  // strobe and qualifier are judged on the latched word, never on the raw pins
  logic [4:0] vidx;
  logic valid_bit, strobe_ev, qual_ok, terr_ev;
  logic [31:0] changed, data_mask, cw_word;
  logic [9:0] nxt_cw;
  logic nxt_cw_valid;
  logic terr_ff, nxt_terr;
  logic [9:0] cw_ff;
  logic cw_valid_ff;

  always_comb begin
    vidx = clamp_idx(cfg_i.valid_idx);
    valid_bit = samp_ff[vidx];
    strobe_ev = samp_new_ff
      && detect(cfg_i.strobe_slope, samp_ff[cfg_i.strobe_idx], prev_samp_ff[cfg_i.strobe_idx]);
    case (cfg_i.valid_pol)
      dctq_pkg::DCTQ_POL_LOW: qual_ok = ~valid_bit;
      dctq_pkg::DCTQ_POL_HIGH: qual_ok = valid_bit;
      default: qual_ok = 1'b1;
    endcase
    cw_word = (cfg_i.data_src == dctq_pkg::DCTQ_SRC_LINK) ? link_data_i : samp_ff;
    // a rejected sample leaves cw_o on the last accepted codeword
    nxt_cw = cw_ff;
    nxt_cw_valid = 1'b0;
    if (cfg_i.data_src == dctq_pkg::DCTQ_SRC_LINK) begin
      // link words bypass strobe and qualifier: the link marks them valid itself
      if (link_valid_i) begin
        nxt_cw = form_cw(cw_word, cfg_i.cw_shift, cfg_i.cw_mask);
        nxt_cw_valid = 1'b1;
      end
    end else if (strobe_ev && qual_ok) begin
      nxt_cw = form_cw(cw_word, cfg_i.cw_shift, cfg_i.cw_mask);
      nxt_cw_valid = 1'b1;
    end
    // strobe line itself is excluded from the stability check
    changed = samp_ff ^ prev_samp_ff;
    data_mask = 32'hFFFFFFFF;
    data_mask[cfg_i.strobe_idx] = 1'b0;
    terr_ev = strobe_ev && ((changed & data_mask) != 32'h00000000)
      && (cfg_i.data_src == dctq_pkg::DCTQ_SRC_PORT);
    // a new violation wins over a clear in the same cycle
    nxt_terr = sticky(terr_ev, err_clear_i, terr_ff);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cw_ff <= 10'h000;
      cw_valid_ff <= 1'b0;
      terr_ff <= 1'b0;
    end else begin
      cw_ff <= nxt_cw;
      cw_valid_ff <= nxt_cw_valid;
      terr_ff <= nxt_terr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger detection

  // an input already high when reset ends is taken as a rising edge
  logic [3:0] trig_prev_ff;
  logic trig_ff, aux_ff, nxt_trig, nxt_aux, trig_hit, aux_hit;
  logic trig_st_ff, aux_st_ff, nxt_trig_st, nxt_aux_st;
  logic port_act_ff, nxt_port_act;

  always_comb begin
    trig_hit = detect(cfg_i.slope, trig_in_i[cfg_i.trig_sel], trig_prev_ff[cfg_i.trig_sel]);
    aux_hit = detect(cfg_i.aux_slope, trig_in_i[cfg_i.aux_sel], trig_prev_ff[cfg_i.aux_sel]);
    // accepted codewords, from the port or the link, also trigger the sequencer
    nxt_trig = trig_hit | nxt_cw_valid;
    nxt_aux = aux_hit;
    nxt_trig_st = sticky(trig_hit, trig_clear_i, trig_st_ff);
    nxt_aux_st = sticky(aux_hit, trig_clear_i, aux_st_ff);
    nxt_port_act = nxt_cw_valid;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trig_prev_ff <= 4'h0;
      trig_ff <= 1'b0;
      aux_ff <= 1'b0;
      trig_st_ff <= 1'b0;
      aux_st_ff <= 1'b0;
      port_act_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_in_i;
      trig_ff <= nxt_trig;
      aux_ff <= nxt_aux;
      trig_st_ff <= nxt_trig_st;
      aux_st_ff <= nxt_aux_st;
      port_act_ff <= nxt_port_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronized start

  // go lasts one cycle and raises the start pulse
  typedef enum logic [1:0] {
    DCTQ_ST_IDLE,
    DCTQ_ST_WAIT,
    DCTQ_ST_GO
  } dctq_start_t;

  dctq_start_t st_ff, nxt_st;
  logic start_ff, nxt_start, all_ready;

  always_comb begin
    all_ready = ((sync_en_all_i & ~sync_ready_all_i) == '0);
    nxt_st = st_ff;
    nxt_start = 1'b0;
    // start requests outside idle are dropped; the sequencer must ask again
    case (st_ff)
      DCTQ_ST_IDLE: begin
        if (start_req_i) begin
          nxt_st = cfg_i.sync_en ? DCTQ_ST_WAIT : DCTQ_ST_GO;
        end
      end
      DCTQ_ST_WAIT: begin
        if (all_ready) begin
          nxt_st = DCTQ_ST_GO;
        end
      end
      default: begin
        nxt_start = 1'b1;
        nxt_st = DCTQ_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= DCTQ_ST_IDLE;
      start_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      start_ff <= nxt_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and outputs

  // high and low bits follow the latched word, so they move at the decimated rate
  dctq_pkg::dctq_stat_t stat_ff, nxt_stat;

  always_comb begin
    nxt_stat.trig_state = nxt_trig_st;
    nxt_stat.aux_state = nxt_aux_st;
    nxt_stat.port_trig_active = nxt_port_act;
    nxt_stat.timing_err = nxt_terr;
    nxt_stat.high_bits = samp_ff;
    nxt_stat.low_bits = ~samp_ff;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign seq_trig_o = trig_ff;
  assign cw_valid_o = cw_valid_ff;
  assign cw_o = cw_ff;
  assign seq_start_o = start_ff;
  assign stat_o = stat_ff;

endmodule

`default_nettype wire

// ==== hdl/dctq_pkg.sv ====
// package: constants, modes and carrier structs of the codeword trigger qualifier
package dctq_pkg;

  localparam int PORT_W = 32;
  localparam int MASK_W = 10;
  localparam int SHIFT_W = 5;
  localparam int IDX_W = 5;
  localparam int NCH_DEF = 4;
  localparam logic [4:0] VALID_IDX_MIN = 5'h10;
  localparam logic [4:0] VALID_IDX_MAX = 5'h1F;
  localparam logic [4:0] VALID_IDX_RST = 5'h10;
  localparam logic [9:0] MASK_RST = 10'h3FF;
  localparam logic [4:0] SHIFT_RST = 5'h00;
  localparam int STROBE_BIT_RST = 0;
  localparam int DECIM_W = 32;
  localparam logic [31:0] DECIM_DEF = 32'h0055D4A8;
  localparam logic [31:0] PORT_RST = 32'h00000000;

  typedef enum logic [1:0] {
    DCTQ_SLOPE_LEVEL,
    DCTQ_SLOPE_RISE,
    DCTQ_SLOPE_FALL,
    DCTQ_SLOPE_BOTH
  } dctq_slope_t;

  typedef enum logic [1:0] {
    DCTQ_POL_NONE,
    DCTQ_POL_LOW,
    DCTQ_POL_HIGH,
    DCTQ_POL_BOTH
  } dctq_pol_t;

  typedef enum logic [1:0] {
    DCTQ_SRC_PORT,
    DCTQ_SRC_LINK
  } dctq_src_t;

  typedef struct packed {
    dctq_slope_t slope;
    dctq_slope_t aux_slope;
    logic [1:0] trig_sel;
    logic [1:0] aux_sel;
    dctq_src_t data_src;
    logic [4:0] valid_idx;
    dctq_pol_t valid_pol;
    logic [4:0] strobe_idx;
    dctq_slope_t strobe_slope;
    logic [9:0] cw_mask;
    logic [4:0] cw_shift;
    logic ext_clk_sel;
    logic [31:0] decim;
    logic sync_en;
  } dctq_cfg_t;

  typedef struct packed {
    logic trig_state;
    logic aux_state;
    logic port_trig_active;
    logic timing_err;
    logic [31:0] high_bits;
    logic [31:0] low_bits;
  } dctq_stat_t;

endpackage

// ==== testbench/dctq_qualifier_chk.sv ====
// checker: port assertions for the codeword trigger qualifier
`timescale 1ns/1ps
`default_nettype none
module dctq_chk #(
  parameter int NCH = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire dctq_pkg::dctq_cfg_t cfg_i,
  input wire logic [31:0] port_i,
  input wire logic [3:0] trig_in_i,
  input wire logic trig_clear_i,
  input wire logic err_clear_i,
  input wire logic [NCH-1:0] sync_en_all_i,
  input wire logic [NCH-1:0] sync_ready_all_i,
  input wire logic seq_trig_o,
  input wire logic cw_valid_o,
  input wire logic [9:0] cw_o,
  input wire logic seq_start_o,
  input wire dctq_pkg::dctq_stat_t stat_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  wire logic rdy = &(sync_ready_all_i | ~sync_en_all_i);
  wire logic qual = port_i[(cfg_i.valid_idx < dctq_pkg::VALID_IDX_MIN) ? dctq_pkg::VALID_IDX_MIN : cfg_i.valid_idx];
  wire logic tin = trig_in_i[cfg_i.trig_sel];
  wire logic [9:0] shf = 10'(port_i >> cfg_i.cw_shift);
  // value checks only hold for undecimated internal sampling of the port
  wire logic pm = cfg_i.data_src == dctq_pkg::DCTQ_SRC_PORT && !cfg_i.ext_clk_sel && cfg_i.decim <= 32'h00000001;
  chk_cw_value: assert property (pm && cw_valid_o |-> cw_o == ($past(shf, 2) & cfg_i.cw_mask))
    else $error("codeword value wrong");
  chk_qual_high: assert property (
    pm && cfg_i.valid_pol == dctq_pkg::DCTQ_POL_HIGH && cw_valid_o |-> $past(qual, 2))
    else $error("codeword taken with qualifier low");
  chk_level_trig: assert property (cfg_i.slope == dctq_pkg::DCTQ_SLOPE_LEVEL && tin [*3] |-> seq_trig_o)
    else $error("level trigger missing");
  chk_rise_trig: assert property (
    cfg_i.slope == dctq_pkg::DCTQ_SLOPE_RISE && $rose(tin) |-> ##[1:2] (seq_trig_o && stat_o.trig_state))
    else $error("edge trigger missing");
  chk_trig_hold: assert property (stat_o.trig_state && !trig_clear_i |=> stat_o.trig_state)
    else $error("trigger status lost");
  chk_aux_hold: assert property (stat_o.aux_state && !trig_clear_i |=> stat_o.aux_state)
    else $error("aux status lost");
  chk_err_hold: assert property (stat_o.timing_err && !err_clear_i |=> stat_o.timing_err)
    else $error("timing error lost");
  chk_bits_inv: assert property (!$past(rst_i) |-> stat_o.low_bits == ~stat_o.high_bits)
    else $error("low bits not inverse of high bits");
  chk_start_gate: assert property (cfg_i.sync_en && seq_start_o |-> $past(rdy, 2))
    else $error("start before channels ready");
  chk_port_active: assert property (cw_valid_o |-> stat_o.port_trig_active)
    else $error("port trigger flag missing");
  cover property (cw_valid_o);
  cover property (seq_start_o);
  cover property (stat_o.timing_err);
endmodule
bind dctq_qualifier dctq_chk #(.NCH(NCH)) u_chk (.clk_sys_i, .rst_i, .cfg_i, .port_i, .trig_in_i, .trig_clear_i,
  .err_clear_i, .sync_en_all_i, .sync_ready_all_i, .seq_trig_o, .cw_valid_o, .cw_o, .seq_start_o, .stat_o);
`default_nettype wire

// ==== testbench/dctq_ctrl_model.sv ====
// partner: external controller presenting codewords with a strobe on port bit 0
`timescale 1ns/1ps
`default_nettype none
module dctq_ctrl (
  input wire logic clk_sys_i,
  output logic [31:0] port_o
);
  initial port_o = 32'h00000000;
  // data moves first and the strobe later; bad moves both in one step
  task automatic send(input logic [31:0] d, input logic bad);
    @(posedge clk_sys_i);
    #1 port_o = {d[31:1], port_o[0] ^ bad};
    repeat (3) @(posedge clk_sys_i);
    #1 port_o[0] = ~port_o[0] ^ bad;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/dctq_qualifier_tb.sv ====
// testbench: scenarios for the codeword trigger qualifier
`timescale 1ns/1ps
`default_nettype none
module dctq_qualifier_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  dctq_pkg::dctq_cfg_t cfg_i;
  wire logic [31:0] port_i;
  logic [31:0] link_data_i = 32'h00000000;
  logic link_valid_i = 1'b0;
  logic [3:0] trig_in_i = 4'h0;
  logic ext_clk = 1'b0;
  logic trig_clear_i = 1'b0;
  logic err_clear_i = 1'b0;
  logic start_req_i = 1'b0;
  logic [3:0] sync_en_all_i = 4'h0;
  logic [3:0] sync_ready_all_i = 4'h0;
  logic seq_trig_o;
  logic cw_valid_o;
  logic [9:0] cw_o;
  logic seq_start_o;
  dctq_pkg::dctq_stat_t stat_o;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int cw_n = 0;
  int st_n = 0;
  int tg_n = 0;
  int n0;
  dctq_ctrl mdl (.clk_sys_i, .port_o(port_i));
  dctq_qualifier #(.NCH(4)) DUT (.clk_sys_i, .rst_i, .cfg_i, .port_i, .link_data_i, .link_valid_i,
    .external_sample_clock_in_i(ext_clk), .trig_in_i, .trig_clear_i, .err_clear_i, .start_req_i, .sync_en_all_i,
    .sync_ready_all_i, .seq_trig_o, .cw_valid_o, .cw_o, .seq_start_o, .stat_o);
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    cw_n <= cw_n + (cw_valid_o === 1'b1);
    st_n <= st_n + (seq_start_o === 1'b1);
    tg_n <= tg_n + (seq_trig_o === 1'b1);
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(3);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // every polarity with qualifier 0 and 1, shifts up to 31
  task automatic t_codewords();
    logic [31:0] d;
    logic [4:0] sh;
    logic [9:0] m;
    logic [9:0] e;
    logic acc;
    e = 10'h000;
    for (int i = 0; i < 8; i++) begin
      sh = (i == 7) ? 5'h1F : 5'(i * 4);
      m = 10'h3FE >> (i % 4);
      d = 32'hA5C36E96 ^ (i * 32'h01010100);
      d[16] = i[2];
      acc = (i[0] == i[1]) || (i[1] == i[2]);
      cfg_i.cw_shift = sh;
      cfg_i.cw_mask = m;
      cfg_i.valid_pol = dctq_pkg::dctq_pol_t'(i[1:0]);
      n0 = cw_n;
      mdl.send(d, 1'b0);
      if (acc) e = 10'(d >> sh) & m;
      check(cw_n - n0, 32'(acc));
      check(32'(cw_o), 32'(e));
      check(stat_o.high_bits, port_i);
      check(stat_o.low_bits, ~port_i);
    end
    // qualifier index below the range must fall back to bit 16, which is low here
    cfg_i.valid_idx = 5'h03;
    cfg_i.valid_pol = dctq_pkg::DCTQ_POL_HIGH;
    n0 = cw_n;
    mdl.send(32'h00000008, 1'b0);
    check(cw_n - n0, 32'h0);
    cfg_i.valid_idx = 5'h10;
  endtask
  task automatic t_timing();
    check(32'(stat_o.timing_err), 32'h0);
    mdl.send(32'h0F0F0000, 1'b1);
    tick(5);
    check(32'(stat_o.timing_err), 32'h1);
    pulse(err_clear_i);
    check(32'(stat_o.timing_err), 32'h0);
  endtask
  task automatic t_trig();
    pulse(trig_clear_i);
    trig_in_i = 4'h8;
    tick(3);
    check(32'(stat_o.trig_state), 32'h0);
    trig_in_i = 4'hE;
    tick(3);
    check(32'({stat_o.trig_state, stat_o.aux_state}), 32'h2);
    trig_in_i = 4'hC;
    tick(3);
    check(32'(stat_o.aux_state), 32'h1);
    pulse(trig_clear_i);
    check(32'({stat_o.trig_state, stat_o.aux_state}), 32'h0);
    trig_in_i = 4'h0;
    tick(2);
    cfg_i.slope = dctq_pkg::DCTQ_SLOPE_LEVEL;
    n0 = tg_n;
    trig_in_i = 4'h4;
    tick(5);
    trig_in_i = 4'h0;
    tick(3);
    check(tg_n - n0, 32'h5);
    cfg_i.slope = dctq_pkg::DCTQ_SLOPE_RISE;
  endtask
  task automatic t_link();
    cfg_i.data_src = dctq_pkg::DCTQ_SRC_LINK;
    n0 = cw_n;
    mdl.send(32'h00010000, 1'b0);
    check(cw_n - n0, 32'h0);
    link_data_i = 32'h00000155;
    cfg_i.cw_shift = 5'h02;
    cfg_i.cw_mask = 10'h3FF;
    pulse(link_valid_i);
    check(cw_n - n0, 32'h1);
    check(32'(cw_o), 32'h055);
    cfg_i.data_src = dctq_pkg::DCTQ_SRC_PORT;
  endtask
  task automatic t_start();
    cfg_i.sync_en = 1'b1;
    sync_en_all_i = 4'h5;
    sync_ready_all_i = 4'h1;
    n0 = st_n;
    pulse(start_req_i);
    tick(8);
    check(st_n - n0, 32'h0);
    sync_ready_all_i = 4'h7;
    tick(6);
    check(st_n - n0, 32'h1);
    cfg_i.sync_en = 1'b0;
    pulse(start_req_i);
    check(st_n - n0, 32'h2);
  endtask
  // external sample clock with decimation 2: only every second rising edge latches the port
  task automatic t_decim();
    logic [31:0] old;
    cfg_i.ext_clk_sel = 1'b1;
    cfg_i.decim = 32'h00000002;
    old = port_i;
    mdl.send(32'h3C5A9600, 1'b0);
    check(stat_o.high_bits, old);
    ext_clk = 1'b1;
    tick(3);
    ext_clk = 1'b0;
    tick(3);
    check(stat_o.high_bits, old);
    ext_clk = 1'b1;
    tick(4);
    check(stat_o.high_bits, port_i);
  endtask
  initial begin
    cfg_i = '0;
    cfg_i.slope = dctq_pkg::DCTQ_SLOPE_RISE;
    cfg_i.aux_slope = dctq_pkg::DCTQ_SLOPE_FALL;
    cfg_i.trig_sel = 2'h2;
    cfg_i.aux_sel = 2'h1;
    cfg_i.valid_idx = 5'h10;
    cfg_i.strobe_slope = dctq_pkg::DCTQ_SLOPE_BOTH;
    cfg_i.decim = 32'h00000001;
    tick(4);
    rst_i = 1'b0;
    tick(2);
    t_codewords();
    t_timing();
    t_trig();
    t_link();
    t_start();
    t_decim();
    conclude();
  end
endmodule
`default_nettype wire
